// [hdl/ccs_pkg.sv]
package ccs_pkg;

  // Clock and timing
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int STEP_NS = 500;
  localparam int STEP_CYC = (STEP_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int CLKSTOP_US = 12;
  localparam int CLKSTOP_CYC = (CLKSTOP_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int WINDOW_US = 200;
  localparam int WINDOW_CYC = (WINDOW_US * CLK_FREQ_KHZ) / 1000;
  localparam int DEBOUNCE_US = 8000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US / 1000) * CLK_FREQ_KHZ;
  localparam int TIMER_W = 18;

  // Channels: 0 data, 1 aux 1, 2 aux 2
  localparam int CHAN_N = 3;

  // Synchroniser bit positions
  localparam int SYNC_W = 18;
  localparam int IDX_REQ = 0;
  localparam int IDX_HRST = 1;
  localparam int IDX_SEL1 = 2;
  localparam int IDX_SEL2 = 3;
  localparam int IDX_DETECT = 4;
  localparam int IDX_DROP = 5;
  localparam int IDX_SUPGOOD = 6;
  localparam int IDX_FAULT0 = 7;
  localparam int IDX_REF = 11;
  localparam int IDX_HOST0 = 12;
  localparam int IDX_CARD0 = 15;
  localparam logic [SYNC_W-1:0] SYNC_RST = 18'h3F001;

  // Clock ratio select {ratio_select_1, ratio_select_2}
  localparam logic [1:0] RATIO_DIV8 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV1 = 2'h2;
  localparam logic [1:0] RATIO_DIV2 = 2'h3;
  localparam logic [1:0] HALF_DIV8 = 2'h3;
  localparam logic [1:0] HALF_DIV4 = 2'h1;
  localparam logic [1:0] HALF_DIV2 = 2'h0;

  // APB map
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CFG_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
  localparam int CFG_OVR_BIT = 0;
  localparam int CFG_RATIO_LSB = 1;
  localparam logic [2:0] CFG_RST = 3'h0;

  typedef enum logic [3:0] {
    ST_STANDBY, ST_RAMP, ST_IO_ON, ST_CLK_ON, ST_ACTIVE,
    ST_DEACT_RST, ST_DEACT_CLK, ST_DONE
  } ccs_state_e;

  typedef enum logic [1:0] {DIR_IDLE, DIR_HOST, DIR_CARD} ccs_dir_e;

  typedef struct packed {
    logic supplyShort;
    logic supplyRange;
    logic regInputLow;
    logic overTemp;
  } ccs_fault_s;

  typedef struct packed {
    logic faultLatched;
    logic presentDebounced;
    logic attention;
    logic gatedMode;
    logic clockRun;
    logic linesOn;
    logic supplyOn;
    logic resetEnabled;
  } ccs_status_s;

endpackage

// [hdl/ccs_clock_divider.sv]
`timescale 1ns/1ps
module ccs_clock_divider
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] ratioSel,
  input wire logic refLevel,
  output logic clkOut
);

  logic refPrev_q, refPrev_d;
  logic [1:0] edgeCnt_q, edgeCnt_d;
  logic clk_q, clk_d;
  logic [1:0] halfLast;
  logic refRise;

  assign refRise = refLevel && !refPrev_q;
  assign clkOut = clk_q;

  // Divided ratios toggle only on reference rising edges, keeping the duty at exactly half; RATIO_DIV1 copies the reference level
  always_comb begin
    case (ratioSel)
      RATIO_DIV8: halfLast = HALF_DIV8;
      RATIO_DIV4: halfLast = HALF_DIV4;
      default: halfLast = HALF_DIV2;
    endcase
    refPrev_d = refLevel;
    edgeCnt_d = edgeCnt_q;
    clk_d = clk_q;
    if (!run) begin
      edgeCnt_d = 2'h0;
      clk_d = 1'b0;
    end else if (ratioSel == RATIO_DIV1) begin
      clk_d = refLevel; // [RL21]
    end else if (refRise) begin
      if (edgeCnt_q == halfLast) begin
        edgeCnt_d = 2'h0;
        clk_d = ~clk_q; // [RL21]
      end else begin
        edgeCnt_d = edgeCnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      refPrev_q <= 1'b0;
      edgeCnt_q <= 2'h0;
      clk_q <= 1'b0;
    end else begin
      refPrev_q <= refPrev_d;
      edgeCnt_q <= edgeCnt_d;
      clk_q <= clk_d;
    end
  end

  a_div_edge_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(run) && $past(ratioSel) != RATIO_DIV1 && $past(clk_q) != clk_q
    |-> $past(refRise)) else $error("Divided clock toggled off a reference edge"); // [RL21]

  a_div_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run |=> !clkOut) else $error("Card clock running while stopped");

endmodule

// [hdl/ccs_card_session_sequencer.sv]
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// RL1 - First falling side drives until both idle
// RL2 - Reset enters standby, card contacts held low
// RL3 - Standby attention shows card presence
// RL4 - Host opens session only with card
// RL5 - Card signals low until supply stable
// RL6 - Lines first, clock one step later
// RL7 - Reset channel one step after clock
// RL8 - Gated mode: host reset high beforehand
// RL9 - Gated: clock starts at host reset fall
// RL10 - Gated: reset low until window, then follows
// RL11 - Normal: clock a step after lines
// RL12 - Deactivation: reset low, clock low later
// RL13 - Lines low after clock, then supply off
// RL14 - Listed conditions count as faults
// RL15 - Pin current limiting gives no indication
// RL16 - Standby dropout drops attention immediately
// RL17 - Session fault: attention low, deactivate
// RL18 - Host re-reads attention after deactivation
// RL19 - Insertion debounced before attention rises
// RL20 - Removal deactivates at once, attention low
// RL21 - Card clock is divided reference, half duty
// RL22 - Supply dropout forces power-down, attention low
// RL23 - All intervals counted on internal clock
module ccs_card_session_sequencer
  import ccs_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic session_request_n,
  input wire logic host_reset_input,
  input wire logic ratio_select_1,
  input wire logic ratio_select_2,
  input wire logic reference_clock_input,
  input wire logic card_detect_input,
  input wire logic supply_dropout_detect,
  input wire logic cardSupplyGood,
  input wire ccs_fault_s cardFaults,
  output logic card_supply,
  output logic card_clock_out,
  output logic card_reset_out,
  output logic attentionN,
  input wire logic [CHAN_N-1:0] hostLineIn,
  output logic [CHAN_N-1:0] hostLineOut,
  output logic [CHAN_N-1:0] hostLineOe,
  input wire logic [CHAN_N-1:0] cardLineIn,
  output logic [CHAN_N-1:0] cardLineOut,
  output logic [CHAN_N-1:0] cardLineOe
);

  logic [SYNC_W-1:0] pinRaw, s1_q, s2_q, s3_q, filt_q, filt_d;
  ccs_state_e state_q, state_d;
  logic [TIMER_W-1:0] stCnt_q, stCnt_d, winCnt_q, winCnt_d, debCnt_q, debCnt_d;
  logic supplyOn_q, supplyOn_d, ioOn_q, ioOn_d, clkRun_q, clkRun_d;
  logic rstEn_q, rstEn_d, gated_q, gated_d, fault_q, fault_d;
  logic present_q, present_d, attn_q, attn_d, resetOut_q, resetOut_d;
  logic reqPrev_q, hrstPrev_q;
  logic reqFell, hrstFell, windowDone, inSession, faultNow, stepDone;
  logic [2:0] cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] ratioSel;
  ccs_status_s status;
  ccs_dir_e dir_q [CHAN_N];
  ccs_dir_e dir_d [CHAN_N];
  logic [CHAN_N-1:0] hostOe_q, hostOe_d, cardOe_q, cardOe_d;

  assign pinRaw = {cardLineIn, hostLineIn, reference_clock_input, cardFaults, cardSupplyGood,
    supply_dropout_detect, card_detect_input, ratio_select_2, ratio_select_1,
    host_reset_input, session_request_n};

  // Three-stage synchroniser; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_comb begin
        filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[g] <= SYNC_RST[g];
          s2_q[g] <= SYNC_RST[g];
          s3_q[g] <= SYNC_RST[g];
          filt_q[g] <= SYNC_RST[g];
        end else begin
          s1_q[g] <= pinRaw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          filt_q[g] <= filt_d[g];
        end
      end
    end
  endgenerate

  assign reqFell = reqPrev_q && !filt_q[IDX_REQ];
  assign hrstFell = hrstPrev_q && !filt_q[IDX_HRST];
  assign windowDone = winCnt_q >= TIMER_W'(WINDOW_CYCLES - 1);
  assign stepDone = stCnt_q == TIMER_W'(STEP_CYC - 1);
  assign inSession = state_q inside {ST_RAMP, ST_IO_ON, ST_CLK_ON, ST_ACTIVE};
  // Pin current limiting has no input here, so it can never reach attention [RL15]
  assign faultNow = !filt_q[IDX_DETECT] || filt_q[IDX_DROP]
    || (|filt_q[IDX_FAULT0 +: 4]); // [RL14] [RL20] [RL22]
  assign ratioSel = cfg_q[CFG_OVR_BIT] ? cfg_q[CFG_RATIO_LSB +: 2]
    : {filt_q[IDX_SEL1], filt_q[IDX_SEL2]};

  always_comb begin
    state_d = state_q;
    stCnt_d = (stCnt_q == {TIMER_W{1'b1}}) ? stCnt_q : stCnt_q + 1'b1;
    winCnt_d = windowDone ? winCnt_q : winCnt_q + 1'b1; // [RL23]
    supplyOn_d = supplyOn_q;
    ioOn_d = ioOn_q;
    clkRun_d = clkRun_q;
    rstEn_d = rstEn_q;
    gated_d = gated_q;
    fault_d = fault_q;
    case (state_q)
      ST_STANDBY: begin
        fault_d = 1'b0;
        if (reqFell && present_q && !filt_q[IDX_DROP]) begin
          state_d = ST_RAMP;
          supplyOn_d = 1'b1;
          gated_d = filt_q[IDX_HRST]; // [RL8]
          winCnt_d = '0;
        end
      end
      ST_RAMP: begin
        if (filt_q[IDX_SUPGOOD]) begin
          state_d = ST_IO_ON;
          ioOn_d = 1'b1; // [RL5]
        end
      end
      ST_IO_ON: begin
        if (gated_q ? (hrstFell || windowDone) : stepDone) begin
          state_d = ST_CLK_ON;
          clkRun_d = 1'b1; // [RL6] [RL9] [RL11]
        end
      end
      ST_CLK_ON: begin
        if (gated_q ? windowDone : stepDone) begin
          state_d = ST_ACTIVE;
          rstEn_d = 1'b1; // [RL7] [RL10]
        end
      end
      ST_DEACT_RST: begin
        if (stCnt_q == TIMER_W'(CLKSTOP_CYC - 1)) begin
          state_d = ST_DEACT_CLK;
          clkRun_d = 1'b0; // [RL12]
        end
      end
      ST_DEACT_CLK: begin
        // Lines drop one cycle after the divider has parked the clock low
        if (stCnt_q == TIMER_W'(1)) begin
          ioOn_d = 1'b0; // [RL13]
        end
        if (stepDone) begin
          state_d = ST_DONE;
          supplyOn_d = 1'b0; // [RL13]
        end
      end
      ST_DONE: begin
        if (filt_q[IDX_REQ]) begin
          state_d = ST_STANDBY;
        end
      end
      default: state_d = state_q;
    endcase
    if (inSession && (filt_q[IDX_REQ] || faultNow)) begin
      state_d = ST_DEACT_RST;
      rstEn_d = 1'b0; // [RL12] [RL17]
      fault_d = fault_q || faultNow;
    end
    if (state_d != state_q) begin
      stCnt_d = '0;
    end
    resetOut_d = rstEn_d && filt_q[IDX_HRST]; // [RL10] [RL11]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_STANDBY; // [RL2]
      stCnt_q <= '0;
      winCnt_q <= '0;
      supplyOn_q <= 1'b0;
      ioOn_q <= 1'b0;
      clkRun_q <= 1'b0;
      rstEn_q <= 1'b0;
      gated_q <= 1'b0;
      fault_q <= 1'b0;
      resetOut_q <= 1'b0;
      reqPrev_q <= 1'b1;
      hrstPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stCnt_q <= stCnt_d;
      winCnt_q <= winCnt_d;
      supplyOn_q <= supplyOn_d;
      ioOn_q <= ioOn_d;
      clkRun_q <= clkRun_d;
      rstEn_q <= rstEn_d;
      gated_q <= gated_d;
      fault_q <= fault_d;
      resetOut_q <= resetOut_d;
      reqPrev_q <= filt_q[IDX_REQ];
      hrstPrev_q <= filt_q[IDX_HRST];
    end
  end

  // Insertion is debounced, removal is not
  always_comb begin
    debCnt_d = debCnt_q;
    present_d = present_q;
    if (!filt_q[IDX_DETECT]) begin
      debCnt_d = '0;
      present_d = 1'b0; // [RL20]
    end else if (!present_q) begin
      debCnt_d = debCnt_q + 1'b1;
      if (debCnt_q == TIMER_W'(DEBOUNCE_CYCLES - 1)) begin
        present_d = 1'b1; // [RL19]
      end
    end
    attn_d = present_d && !filt_q[IDX_DROP] && !fault_d; // [RL3] [RL16] [RL17]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debCnt_q <= '0;
      present_q <= 1'b0;
      attn_q <= 1'b0;
    end else begin
      debCnt_q <= debCnt_d;
      present_q <= present_d;
      attn_q <= attn_d;
    end
  end

  ccs_clock_divider u_divider (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(clkRun_q),
    .ratioSel(ratioSel),
    .refLevel(filt_q[IDX_REF]),
    .clkOut(card_clock_out)
  );

  // Open-drain style level shifters; pull-ups sit outside
  generate
    for (g = 0; g < CHAN_N; g++) begin : g_chan
      logic hLow, cLow;
      assign hLow = !filt_q[IDX_HOST0 + g];
      assign cLow = !filt_q[IDX_CARD0 + g];
      always_comb begin
        dir_d[g] = dir_q[g];
        if (!ioOn_q) begin
          dir_d[g] = DIR_IDLE;
        end else if (dir_q[g] == DIR_IDLE) begin
          if (hLow) begin
            dir_d[g] = DIR_HOST; // [RL1]
          end else if (cLow) begin
            dir_d[g] = DIR_CARD; // [RL1]
          end
        end else if (!hLow && !cLow) begin
          dir_d[g] = DIR_IDLE; // [RL1]
        end
        hostOe_d[g] = ioOn_q && dir_d[g] == DIR_CARD && cLow;
        cardOe_d[g] = !ioOn_q || (dir_d[g] == DIR_HOST && hLow); // [RL2]
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          dir_q[g] <= DIR_IDLE;
          hostOe_q[g] <= 1'b0;
          cardOe_q[g] <= 1'b1;
        end else begin
          dir_q[g] <= dir_d[g];
          hostOe_q[g] <= hostOe_d[g];
          cardOe_q[g] <= cardOe_d[g];
        end
      end
      a_dir_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ioOn_q && dir_q[g] == DIR_HOST && hLow |=> dir_q[g] == DIR_HOST)
        else $error("Channel direction changed while busy"); // [RL1]
    end
  endgenerate

  // APB slave: no wait states, read data captured in the setup cycle
  always_comb begin
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (psel && penable && pwrite && paddr == CFG_OFS) begin
      cfg_d = pwdata[2:0];
    end
    if (psel && !penable) begin
      case (paddr)
        CFG_OFS: rdata_d = {29'h0, cfg_q};
        STATUS_OFS: rdata_d = {24'h0, status};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
      rdata_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign status = '{faultLatched: fault_q, presentDebounced: present_q, attention: attn_q,
    gatedMode: gated_q, clockRun: clkRun_q, linesOn: ioOn_q, supplyOn: supplyOn_q,
    resetEnabled: rstEn_q};
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != CFG_OFS && paddr != STATUS_OFS;
  assign card_supply = supplyOn_q;
  assign card_reset_out = resetOut_q;
  assign attentionN = attn_q;
  assign hostLineOut = 3'h0;
  assign hostLineOe = hostOe_q;
  assign cardLineOut = 3'h0;
  assign cardLineOe = cardOe_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_standby_quiet: assert property (state_q == ST_STANDBY
    |-> !card_supply && !card_reset_out && (&cardLineOe) && hostLineOe == 3'h0)
    else $error("Card contacts active in standby"); // [RL2]
  a_lines_need_supply: assert property (state_q == ST_RAMP
    |-> (&cardLineOe) && !card_clock_out && !card_reset_out)
    else $error("Card signal active during supply ramp"); // [RL5]
  a_normal_clock_step: assert property (!gated_q && $rose(clkRun_q)
    |-> $past(state_q) == ST_IO_ON && $past(stCnt_q) == TIMER_W'(STEP_CYC - 1))
    else $error("Clock started off the step after lines"); // [RL11]
  a_reset_after_clock: assert property (!gated_q && $rose(rstEn_q)
    |-> clkRun_q && $past(stCnt_q) == TIMER_W'(STEP_CYC - 1))
    else $error("Reset channel enabled off the step"); // [RL7]
  a_gated_clock_start: assert property (gated_q && state_q == ST_IO_ON && hrstFell
    && !windowDone && !faultNow && !filt_q[IDX_REQ] |=> clkRun_q)
    else $error("Gated clock missed host reset fall"); // [RL9]
  a_gated_reset_hold: assert property (gated_q && !windowDone |-> !rstEn_q ##1 !card_reset_out)
    else $error("Card reset released inside window"); // [RL10]
  a_deact_clock_stop: assert property ($fell(clkRun_q) && state_q == ST_DEACT_CLK
    |-> $past(stCnt_q) == TIMER_W'(CLKSTOP_CYC - 1) && !card_reset_out)
    else $error("Clock stop not 12 us after reset"); // [RL12]
  a_supply_after_lines: assert property ($fell(supplyOn_q) |-> (&cardOe_q) && !card_clock_out)
    else $error("Supply cut before lines low"); // [RL13]
  a_fault_deactivates: assert property (inSession && faultNow
    |=> state_q == ST_DEACT_RST ##1 !attentionN)
    else $error("Fault did not deactivate"); // [RL17]
  a_debounce_time: assert property ($rose(present_q)
    |-> $past(debCnt_q) == TIMER_W'(DEBOUNCE_CYCLES - 1))
    else $error("Presence accepted before debounce end"); // [RL19]
  a_dropout_attention: assert property (filt_q[IDX_DROP] |=> !attentionN)
    else $error("Attention high under supply dropout"); // [RL16]

endmodule

// [sim/ccs_host_model.sv]
`timescale 1ns/1ps
module ccs_host_model (
  input wire logic clk_sys,
  input wire logic attentionN,
  input wire logic card_supply,
  output logic session_request_n,
  output logic host_reset_input
);
  initial begin
    session_request_n = 1'b1;
    host_reset_input = 1'b0;
  end

  task automatic setReset(input logic v);
    @(posedge clk_sys);
    host_reset_input <= v;
  endtask

  // Mode is chosen by the reset level, so it settles before the request falls
  task automatic openSession(input logic gated);
    int k;
    for (k = 0; k < 200 && attentionN !== 1'b1; k++) @(posedge clk_sys);
    setReset(gated);
    repeat (6) @(posedge clk_sys);
    session_request_n <= 1'b0;
  endtask

  // Attention is only trusted again once the card supply is off
  task automatic closeSession();
    int k;
    @(posedge clk_sys);
    session_request_n <= 1'b1;
    for (k = 0; k < 500 && card_supply !== 1'b0; k++) @(posedge clk_sys);
  endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ccs_pkg::*;
  localparam int WIN = 200;
  localparam int DEB = 50;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic session_request_n, host_reset_input;
  logic ratio_select_1 = 1'b0;
  logic ratio_select_2 = 1'b0;
  logic reference_clock_input = 1'b0;
  logic card_detect_input = 1'b0;
  logic supply_dropout_detect = 1'b0;
  logic cardSupplyGood = 1'b0;
  ccs_fault_s cardFaults = '0;
  logic card_supply, card_clock_out, card_reset_out, attentionN;
  logic [CHAN_N-1:0] hostLineIn, hostLineOut, hostLineOe, cardLineIn, cardLineOut, cardLineOe;
  logic [CHAN_N-1:0] hostPull = '0;
  logic [CHAN_N-1:0] cardPull = '0;
  int fails = 0;
  int nTests = 0;
  int cycles = 0;
  int edges = 0;
  int lastClk, tRst, tOff, t0, t1, n, k, i;
  int expEdges[4] = '{8, 16, 64, 32};

  ccs_card_session_sequencer #(.WINDOW_CYCLES(WIN), .DEBOUNCE_CYCLES(DEB))
      ccs_card_session_sequencer_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .session_request_n(session_request_n), .host_reset_input(host_reset_input),
    .ratio_select_1(ratio_select_1), .ratio_select_2(ratio_select_2),
    .reference_clock_input(reference_clock_input), .card_detect_input(card_detect_input),
    .supply_dropout_detect(supply_dropout_detect), .cardSupplyGood(cardSupplyGood),
    .cardFaults(cardFaults), .card_supply(card_supply), .card_clock_out(card_clock_out),
    .card_reset_out(card_reset_out), .attentionN(attentionN), .hostLineIn(hostLineIn),
    .hostLineOut(hostLineOut), .hostLineOe(hostLineOe), .cardLineIn(cardLineIn),
    .cardLineOut(cardLineOut), .cardLineOe(cardLineOe)
  );

  ccs_host_model ccs_host_model_i (
    .clk_sys(clk_sys), .attentionN(attentionN), .card_supply(card_supply),
    .session_request_n(session_request_n), .host_reset_input(host_reset_input)
  );

  // Pull-ups on every channel end; any low driver wins
  assign hostLineIn = ~(hostLineOe | hostPull);
  assign cardLineIn = ~(cardLineOe | cardPull);

  always #20 clk_sys = ~clk_sys;

  // Slow reference keeps well inside the sampling limit of the design
  always begin
    repeat (4) @(posedge clk_sys);
    reference_clock_input <= ~reference_clock_input;
  end

  always @(card_clock_out) begin
    edges++;
    lastClk = cycles;
  end
  always @(negedge card_reset_out) tRst = cycles;
  always @(negedge card_supply) tOff = cycles;

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task summarize();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task inRange(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask

  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int j;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (j = 0; j < 16 && pready !== 1'b1; j++) @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(2);
    check(32'(card_supply), 32'h0);
    check(32'(card_clock_out), 32'h0);
    check(32'(card_reset_out), 32'h0);
    check(32'(cardLineOe), 32'h7);
    check(32'(hostLineOe), 32'h0);
    check(32'(attentionN), 32'h0);
    apb(1'b0, CFG_OFS, 32'h0);
    check(q, 32'(CFG_RST));
    apb(1'b1, CFG_OFS, 32'h5);
    apb(1'b0, CFG_OFS, 32'h0);
    check(q, 32'h5);
    apb(1'b1, STATUS_OFS, 32'hFF);
    check(32'(e), 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(q[3:0]), 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(q, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    check(32'(e), 32'h1);
    card_detect_input <= 1'b1;
    cyc(DEB - 20);
    check(32'(attentionN), 32'h0);
    cyc(40);
    check(32'(attentionN), 32'h1);
    supply_dropout_detect <= 1'b1;
    cyc(8);
    check(32'(attentionN), 32'h0);
    supply_dropout_detect <= 1'b0;
    cyc(8);
    check(32'(attentionN), 32'h1);
    ccs_host_model_i.openSession(1'b0);
    for (k = 0; k < 20 && card_supply !== 1'b1; k++) @(posedge clk_sys);
    cyc(5);
    check(32'(cardLineOe), 32'h7);
    check(32'({card_clock_out, card_reset_out}), 32'h0);
    cardSupplyGood <= 1'b1;
    for (k = 0; k < 40 && cardLineOe === 3'h7; k++) @(posedge clk_sys);
    t0 = cycles;
    n = edges;
    ccs_host_model_i.setReset(1'b1);
    for (k = 0; k < 60 && edges == n; k++) @(posedge clk_sys);
    inRange(cycles - t0, 12, 24);
    for (k = 0; k < 60 && card_reset_out !== 1'b1; k++) @(posedge clk_sys);
    inRange(cycles - t0, 25, 40);
    hostPull <= 3'h1;
    cyc(8);
    check(32'({hostLineOe, cardLineOe}), 32'h01);
    cardPull <= 3'h1;
    hostPull <= 3'h0;
    cyc(8);
    check(32'(hostLineOe), 32'h0);
    cardPull <= 3'h0;
    cyc(8);
    check(32'({hostLineOe, cardLineOe}), 32'h00);
    cardPull <= 3'h4;
    cyc(8);
    check(32'({hostLineOe, cardLineOe}), 32'h20);
    cardPull <= 3'h0;
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'({q[6], q[3:0]}), 32'h1F);
    check(32'({hostLineOut, cardLineOut, pready}), 32'h1);
    apb(1'b1, CFG_OFS, 32'h0);
    for (i = 0; i < 4; i++) begin
      ratio_select_1 <= i[1];
      ratio_select_2 <= i[0];
      cyc(64);
      n = edges;
      cyc(256);
      inRange(edges - n, expEdges[i] - 2, expEdges[i] + 2);
    end
    apb(1'b1, CFG_OFS, 32'h5);
    t0 = cycles;
    ccs_host_model_i.closeSession();
    inRange(tRst - t0, 1, 8);
    inRange(lastClk - tRst, 295, 305);
    check(32'({card_clock_out, cardLineOe}), 32'h7);
    inRange(tOff - lastClk, 1, 40);
    ccs_host_model_i.openSession(1'b1);
    for (k = 0; k < 20 && card_supply !== 1'b1; k++) @(posedge clk_sys);
    t0 = cycles;
    for (k = 0; k < 40 && cardLineOe === 3'h7; k++) @(posedge clk_sys);
    n = edges;
    cyc(30);
    check(32'(edges - n), 32'h0);
    ccs_host_model_i.setReset(1'b0);
    t1 = cycles;
    for (k = 0; k < 40 && edges == n; k++) @(posedge clk_sys);
    inRange(cycles - t1, 2, 14);
    ccs_host_model_i.setReset(1'b1);
    while (cycles - t0 < WIN - 20) @(posedge clk_sys);
    check(32'(card_reset_out), 32'h0);
    while (cycles - t0 < WIN + 15) @(posedge clk_sys);
    check(32'(card_reset_out), 32'h1);
    ccs_host_model_i.setReset(1'b0);
    n = edges;
    cyc(32);
    check(32'(card_reset_out), 32'h0);
    inRange(edges - n, 6, 10);
    ccs_host_model_i.closeSession();
    // Every fault kind, then a dropout, then a removal, each mid-session
    for (i = 0; i < 6; i++) begin
      ccs_host_model_i.openSession(1'b0);
      for (k = 0; k < 60 && cardLineOe === 3'h7; k++) @(posedge clk_sys);
      ccs_host_model_i.setReset(1'b1);
      cyc(40);
      if (i < 4) begin
        cardFaults <= ccs_fault_s'(4'h8 >> i);
      end else if (i == 4) begin
        supply_dropout_detect <= 1'b1;
      end else begin
        card_detect_input <= 1'b0;
      end
      cyc(8);
      check(32'({attentionN, card_reset_out}), 32'h0);
      for (k = 0; k < 400 && card_supply !== 1'b0; k++) @(posedge clk_sys);
      check(32'({card_supply, cardLineOe}), 32'h7);
      ccs_host_model_i.closeSession();
      cardFaults <= '0;
      supply_dropout_detect <= 1'b0;
      card_detect_input <= 1'b1;
      cyc(DEB + 30);
      check(32'(attentionN), 32'h1);
    end
    summarize();
  end
endmodule
